//--- logic/cbf_defs.svh
// Constants shared by both ends of the command block framer.
`ifndef CBF_DEFS_SVH
`define CBF_DEFS_SVH
// ==========================================================================
// Block framing
`define CBF_CNT_MIN      8'd4
`define CBF_CNT_MAX      8'd84
`define CBF_CRC_POLY     16'h8005
`define CBF_CRC_INIT     16'h0000
`define CBF_RSP_LEN      8'h04
`define CBF_PKT_OVERHEAD 8'd3
// ==========================================================================
// Status codes of a four-byte response
`define CBF_ST_OK        8'h00
`define CBF_ST_PARSE     8'h03
`define CBF_ST_EXEC      8'h0f
`define CBF_ST_WAKE      8'h11
`define CBF_ST_CRC       8'hff
// ==========================================================================
// Timing
`define CBF_CLK_MHZ         200
`define CBF_IDLE_TIMEOUT_MS 65
`define CBF_IDLE_CYCLES (`CBF_IDLE_TIMEOUT_MS * `CBF_CLK_MHZ * 1000)
`endif

//--- logic/cbf_dev.sv
// Device end: receives, checks and splits command blocks, answers status.
//
// Contract
// - Count byte equals total block length.
// - Host keeps block length four to 84.
// - CRC-16, polynomial 8005, cleared each block.
// - Compare running CRC with received checksum.
// - Checksum sent low byte, then high.
// - Packet: opcode, first, second parameter, data.
// - Full block received enters busy, executes.
// - No response bytes readable while busy.
// - Link input ignored during execution.
// - Single-wire short block sleeps after idle timeout.
// - I2C short block waits for watchdog or event.
// - Wrong block size: no execution, error returned.
// - Count mismatch: error or surplus bytes dropped.
// - Responses framed as count, packet, CRC.
// - Status codes 00, 03, 0F, 11, FF.
// - CRC error first; bad block never executed.
// - Idle timeout lasts 65 ms.
`timescale 1ns/1ps
`include "cbf_defs.svh"
module cbf_dev #(
    parameter int unsigned IDLE_CYCLES = `CBF_IDLE_CYCLES // Idle timeout.
) (
    input  wire logic       clk,                // 200 MHz clock.
    input  wire logic       rst,                // Synchronous reset.
    cbf_if.dev              lnk,                // Link to the host.
    input  wire logic       mode_i2c,           // 1: I2C, 0: single-wire.
    input  wire logic       watchdog_expire,    // Awake watchdog ran out.
    input  wire logic       exec_done,          // Executor finished.
    input  wire logic       exec_reject,        // Block size wrong.
    input  wire logic [7:0] exec_status,        // Executor status code.
    input  wire logic [6:0] data_idx,           // Data byte to look at.
    output logic            cmd_valid_q,        // New command, one cycle.
    output logic [7:0]      opcode_q,           // Command code.
    output logic [7:0]      first_parameter_q,  // First parameter.
    output logic [15:0]     second_parameter_q, // Second parameter.
    output logic [6:0]      pkt_len_q,          // Packet bytes received.
    output logic [7:0]      data_byte_q,        // Data byte at data_idx.
    output logic            busy_q,             // Command executing.
    output logic            asleep_q            // In sleep state.
);
    import cbf_pkg::*;

    localparam int unsigned MEM_DEPTH = int'(`CBF_CNT_MAX);

    cbf_dev_state_t st_q;
    cbf_byte_t      mem_q [MEM_DEPTH];
    logic [7:0]     cnt_q;
    logic [7:0]     idx_q;
    logic [15:0]    crc_q;
    logic [7:0]     lo_q;
    logic [31:0]    idle_q;
    logic [1:0]     tx_idx_q;
    logic [7:0]     tx_st_q;
    logic [15:0]    tx_crc_q;
    logic           take;
    logic           last;
    logic           crc_ok;
    logic           partial;
    logic           abandon;
    logic           sleep_go;
    logic           drain;
    logic           load;
    logic [7:0]     load_st;

    // ======================================================================
    // Receive decisions. Bytes are only taken while not executing or
    // asleep, so a host that talks during execution is simply unheard.
    assign take    = lnk.h2d_valid &&
                     (st_q == CBF_RX || st_q == CBF_TX);
    assign last    = take && idx_q != 8'h00 &&
                     idx_q == cnt_q - 8'h01;
    assign crc_ok  = (crc_q == {lnk.h2d_data, lo_q});
    assign partial = st_q == CBF_RX && idx_q != 8'h00 && !take;
    assign abandon = partial && mode_i2c && lnk.h2d_event;
    assign sleep_go = partial &&
                     ((!mode_i2c && idle_q >= IDLE_CYCLES - 1) ||
                      (mode_i2c && watchdog_expire));
    assign drain   = lnk.d2h_valid && lnk.d2h_ready;

    // ======================================================================
    // Which status to answer with, and when.
    always_comb begin
        load    = 1'b0;
        load_st = `CBF_ST_OK;
        if (last && !crc_ok) begin
            load    = 1'b1;
            load_st = `CBF_ST_CRC;
        end else if (st_q == CBF_EXEC && exec_done) begin
            load    = 1'b1;
            load_st = exec_reject ? `CBF_ST_PARSE : exec_status;
        end else if (st_q == CBF_SLEEP && lnk.h2d_valid) begin
            load    = 1'b1;
            load_st = `CBF_ST_WAKE;
        end
    end

    // ======================================================================
    // Main sequence.
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= CBF_SLEEP;
        end else if (last && crc_ok) begin
            st_q <= CBF_EXEC;
        end else if (load) begin
            st_q <= CBF_TX;
        end else if (sleep_go) begin
            st_q <= CBF_SLEEP;
        end else if (st_q == CBF_TX && take) begin
            // A new block cancels the answer; without this the device
            // would sit in TX where no idle timeout or watchdog applies.
            st_q <= CBF_RX;
        end else if (st_q == CBF_TX && drain && tx_idx_q == 2'd3) begin
            st_q <= CBF_RX;
        end
    end

    // ======================================================================
    // Byte position within the incoming block and its count.
    always_ff @(posedge clk) begin
        if (rst || abandon || sleep_go || last) begin
            idx_q <= 8'h00;
            cnt_q <= 8'h00;
        end else if (take) begin
            idx_q <= idx_q + 8'h01;
            if (idx_q == 8'h00) begin
                cnt_q <= lnk.h2d_data;
            end
        end
    end

    // ======================================================================
    // Running CRC over count and packet; checksum bytes are not fed in.
    always_ff @(posedge clk) begin
        if (rst || abandon || sleep_go || last) begin
            crc_q <= `CBF_CRC_INIT;
            lo_q  <= 8'h00;
        end else if (take) begin
            if (idx_q == 8'h00 || idx_q < cnt_q - 8'd2) begin
                crc_q <= cbf_crc_byte(crc_q, lnk.h2d_data);
            end else begin
                lo_q <= lnk.h2d_data;
            end
        end
    end

    // ======================================================================
    // Packet storage. Bytes past the buffer are dropped; the count is
    // kept to the documented maximum by the host.
    generate
        for (genvar g = 0; g < MEM_DEPTH; g++) begin : g_mem
            always_ff @(posedge clk) begin
                if (rst) begin
                    mem_q[g] <= 8'h00;
                end else if (take && idx_q == 8'(g + 1) &&
                             idx_q < cnt_q - 8'd2) begin
                    mem_q[g] <= lnk.h2d_data;
                end
            end
        end
    endgenerate

    // ======================================================================
    // Command fields, offered only once the checksum has matched.
    always_ff @(posedge clk) begin
        cmd_valid_q <= 1'b0;
        if (rst) begin
            opcode_q           <= 8'h00;
            first_parameter_q  <= 8'h00;
            second_parameter_q <= 16'h0000;
            pkt_len_q          <= 7'h00;
        end else if (last && crc_ok) begin
            cmd_valid_q        <= 1'b1;
            opcode_q           <= mem_q[0];
            first_parameter_q  <= mem_q[1];
            second_parameter_q <= {mem_q[3], mem_q[2]};
            pkt_len_q          <= 7'(cnt_q - `CBF_PKT_OVERHEAD);
        end
    end

    // Data bytes from position 4 on; surplus is the executor's to ignore.
    always_ff @(posedge clk) begin
        if (rst) begin
            data_byte_q <= 8'h00;
        end else if (int'(data_idx) + 4 < MEM_DEPTH) begin
            data_byte_q <= mem_q[int'(data_idx) + 4];
        end else begin
            data_byte_q <= 8'h00;
        end
    end

    // ======================================================================
    // Idle timer of the single-wire link, restarted by every byte.
    always_ff @(posedge clk) begin
        if (rst || take || !partial) begin
            idle_q <= 32'h0;
        end else if (idle_q < IDLE_CYCLES) begin
            idle_q <= idle_q + 32'h1;
        end
    end

    // ======================================================================
    // Four-byte status response: count, status, CRC low, CRC high.
    always_ff @(posedge clk) begin
        if (rst) begin
            tx_idx_q      <= 2'd0;
            tx_st_q       <= 8'h00;
            tx_crc_q      <= `CBF_CRC_INIT;
            lnk.d2h_valid <= 1'b0;
            lnk.d2h_data  <= 8'h00;
        end else if (load) begin
            tx_idx_q      <= 2'd0;
            tx_st_q       <= load_st;
            tx_crc_q      <= cbf_crc_byte(cbf_crc_byte(`CBF_CRC_INIT,
                                `CBF_RSP_LEN), load_st);
            lnk.d2h_valid <= 1'b1;
            lnk.d2h_data  <= `CBF_RSP_LEN;
        end else if (st_q != CBF_TX || take) begin
            lnk.d2h_valid <= 1'b0;
        end else if (drain) begin
            tx_idx_q <= tx_idx_q + 2'd1;
            unique case (tx_idx_q)
                2'd0: lnk.d2h_data <= tx_st_q;
                2'd1: lnk.d2h_data <= tx_crc_q[7:0];
                2'd2: lnk.d2h_data <= tx_crc_q[15:8];
                2'd3: lnk.d2h_valid <= 1'b0;
            endcase
        end
    end

    // ======================================================================
    // Status levels for the surrounding logic.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_q   <= 1'b0;
            asleep_q <= 1'b1;
        end else begin
            busy_q   <= (st_q == CBF_EXEC && !exec_done) ||
                        (last && crc_ok);
            asleep_q <= (st_q == CBF_SLEEP && !load) || sleep_go;
        end
    end
endmodule : cbf_dev

//--- logic/cbf_host.sv
// Host end: frames a command block and checks the response block.
`timescale 1ns/1ps
`include "cbf_defs.svh"
module cbf_host (
    input  wire logic       clk,           // 200 MHz clock.
    input  wire logic       rst,           // Synchronous reset.
    cbf_if.host             lnk,           // Link to the device.
    input  wire logic       cmd_start,     // Begin a command.
    input  wire logic [6:0] cmd_len,       // Packet bytes in the command.
    input  wire logic [7:0] tx_byte,       // Current packet byte.
    output logic            tx_next_q,     // Byte on tx_byte was taken.
    output logic            cmd_refused_q, // Length out of range.
    output logic            rsp_valid_q,   // Response packet byte.
    output logic [7:0]      rsp_byte_q,    // Response packet byte value.
    output logic            rsp_done_q,    // Response complete.
    output logic            rsp_crc_ok_q   // Response checksum matched.
);
    import cbf_pkg::*;

    cbf_host_state_t st_q;
    logic [7:0]      cnt_q;
    logic [7:0]      idx_q;
    logic [15:0]     crc_q;
    logic [7:0]      lo_q;
    logic            ph_q;
    logic [7:0]      cnt_d;
    logic            rd;

    assign cnt_d = {1'b0, cmd_len} + `CBF_PKT_OVERHEAD;
    assign rd    = lnk.d2h_valid && lnk.d2h_ready;

    // ======================================================================
    // Sending: count, packet, CRC low then high, one byte every two
    // cycles so the user has a cycle to present the next packet byte.
    always_ff @(posedge clk) begin
        lnk.h2d_valid <= 1'b0;
        lnk.h2d_event <= 1'b0;
        tx_next_q     <= 1'b0;
        cmd_refused_q <= 1'b0;
        if (rst) begin
            st_q          <= CBF_H_IDLE;
            cnt_q         <= 8'h00;
            idx_q         <= 8'h00;
            ph_q          <= 1'b0;
            lnk.h2d_data  <= 8'h00;
            lnk.d2h_ready <= 1'b0;
        end else begin
            unique case (st_q)
                CBF_H_IDLE: begin
                    if (cmd_start) begin
                        if (cnt_d < `CBF_CNT_MIN ||
                            cnt_d > `CBF_CNT_MAX) begin
                            cmd_refused_q <= 1'b1;
                        end else begin
                            st_q          <= CBF_H_SEND;
                            cnt_q         <= cnt_d;
                            idx_q         <= 8'h00;
                            ph_q          <= 1'b0;
                            lnk.h2d_event <= 1'b1;
                        end
                    end
                end
                CBF_H_SEND: begin
                    ph_q <= ~ph_q;
                    if (ph_q) begin
                        lnk.h2d_valid <= 1'b1;
                        idx_q         <= idx_q + 8'h01;
                        if (idx_q == 8'h00) begin
                            lnk.h2d_data <= cnt_q;
                        end else if (idx_q < cnt_q - 8'd2) begin
                            lnk.h2d_data <= tx_byte;
                            tx_next_q    <= 1'b1;
                        end else if (idx_q == cnt_q - 8'd2) begin
                            lnk.h2d_data <= crc_q[7:0];
                        end else begin
                            lnk.h2d_data  <= crc_q[15:8];
                            st_q          <= CBF_H_RECV;
                            idx_q         <= 8'h00;
                            lnk.d2h_ready <= 1'b1;
                        end
                    end
                end
                CBF_H_RECV: begin
                    if (rd) begin
                        idx_q <= idx_q + 8'h01;
                        if (idx_q == 8'h00) begin
                            cnt_q <= lnk.d2h_data;
                        end else if (idx_q == cnt_q - 8'h01) begin
                            st_q          <= CBF_H_IDLE;
                            lnk.d2h_ready <= 1'b0;
                        end
                    end
                end
                default: st_q <= CBF_H_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Running CRC over count and packet bytes, cleared per block.
    always_ff @(posedge clk) begin
        if (rst || (st_q == CBF_H_IDLE && cmd_start)) begin
            crc_q <= `CBF_CRC_INIT;
        end else if (st_q == CBF_H_SEND && ph_q && idx_q < cnt_q - 8'd2) begin
            crc_q <= cbf_crc_byte(crc_q, idx_q == 8'h00 ? cnt_q : tx_byte);
        end else if (st_q == CBF_H_SEND && ph_q && idx_q == cnt_q - 8'd1) begin
            crc_q <= `CBF_CRC_INIT;
        end else if (rd && (idx_q == 8'h00 || idx_q < cnt_q - 8'd2)) begin
            crc_q <= cbf_crc_byte(crc_q, lnk.d2h_data);
        end
    end

    // ======================================================================
    // Response packet bytes and the final checksum verdict.
    always_ff @(posedge clk) begin
        rsp_valid_q <= 1'b0;
        rsp_done_q  <= 1'b0;
        if (rst) begin
            rsp_byte_q   <= 8'h00;
            rsp_crc_ok_q <= 1'b0;
            lo_q         <= 8'h00;
        end else if (st_q == CBF_H_RECV && rd && idx_q != 8'h00) begin
            if (idx_q < cnt_q - 8'd2) begin
                rsp_valid_q <= 1'b1;
                rsp_byte_q  <= lnk.d2h_data;
            end else if (idx_q == cnt_q - 8'd2) begin
                lo_q <= lnk.d2h_data;
            end else begin
                rsp_done_q   <= 1'b1;
                rsp_crc_ok_q <= (crc_q == {lnk.d2h_data, lo_q});
            end
        end
    end
endmodule : cbf_host

//--- logic/cbf_if.sv
// Byte-level link between the host end and the device end.
`timescale 1ns/1ps
interface cbf_if;
    logic       h2d_valid; // Host byte present, one-cycle pulse.
    logic [7:0] h2d_data;  // Host byte.
    logic       h2d_event; // Start or stop condition, one-cycle pulse.
    logic       d2h_valid; // Device byte available for reading.
    logic [7:0] d2h_data;  // Device byte.
    logic       d2h_ready; // Host reads the byte when high with valid.

    modport dev  (input h2d_valid, h2d_data, h2d_event, d2h_ready,
                  output d2h_valid, d2h_data);
    modport host (output h2d_valid, h2d_data, h2d_event, d2h_ready,
                  input d2h_valid, d2h_data);
endinterface : cbf_if

//--- logic/cbf_pkg.sv
// Types and the CRC step shared by both ends of the framer.
package cbf_pkg;
    `include "cbf_defs.svh"

    typedef logic [7:0] cbf_byte_t;

    typedef enum logic [1:0] {
        CBF_RX,
        CBF_EXEC,
        CBF_TX,
        CBF_SLEEP
    } cbf_dev_state_t;

    typedef enum logic [1:0] {
        CBF_H_IDLE,
        CBF_H_SEND,
        CBF_H_RECV
    } cbf_host_state_t;

    // ======================================================================
    // CRC step: one byte, least significant bit first.
    function automatic logic [15:0] cbf_crc_byte(input logic [15:0] crc,
                                                 input cbf_byte_t   data);
        logic [15:0] c;
        c = crc;
        for (int i = 0; i < 8; i++) begin
            if (data[i] != c[15]) begin
                c = {c[14:0], 1'b0} ^ `CBF_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        return c;
    endfunction : cbf_crc_byte
endpackage : cbf_pkg

//--- verif/cbf_link_sva.sv
// Wire-level checks on the link between the framer's two ends.
`timescale 1ns/1ps
module cbf_link_sva (
    input wire logic       clk,       // Link clock.
    input wire logic       rst,       // Device reset.
    input wire logic       h2d_valid, // Host byte pulse.
    input wire logic [7:0] h2d_data,  // Host byte.
    input wire logic       h2d_event, // Start or stop pulse.
    input wire logic       d2h_valid, // Device byte readable.
    input wire logic [7:0] d2h_data,  // Device byte.
    input wire logic       d2h_ready  // Host takes the byte.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ======================================================================
    // Helper state
    logic [1:0]  take_n_q; // Response bytes taken so far.
    logic [15:0] crc_q;    // Own checksum over count and status.
    logic        ev_q;     // Event seen, count byte still due.
    wire         take = d2h_valid & d2h_ready;

    // Kept apart from the design's step so a shared slip cannot hide.
    function automatic logic [15:0] step(input logic [15:0] c,
                                         input logic [7:0]  d);
        for (int i = 0; i < 8; i++) begin
            c = (d[i] ^ c[15]) ? ({c[14:0], 1'b0} ^ 16'h8005)
                               : {c[14:0], 1'b0};
        end
        return c;
    endfunction : step

    // Count taken bytes and fold the first two into the checksum.
    always_ff @(posedge clk) begin
        if (rst) begin
            take_n_q <= 2'h0;
            crc_q    <= 16'h0000;
        end else if (take) begin
            take_n_q <= take_n_q + 2'h1;
            crc_q    <= (take_n_q == 2'h3) ? 16'h0000
                      : (take_n_q[1] ? crc_q : step(crc_q, d2h_data));
        end
    end

    // Remember that the next host byte opens a block.
    always_ff @(posedge clk) begin
        if (rst || h2d_valid) begin
            ev_q <= 1'b0;
        end else if (h2d_event) begin
            ev_q <= 1'b1;
        end
    end
    // ======================================================================
    // Assertions
    host_byte_pulse_a: assert property (h2d_valid |=> !h2d_valid)
        else $error("host byte held for more than one cycle");
    event_count_a: assert property (h2d_event |-> ##[1:4] h2d_valid)
        else $error("no count byte after block start");
    count_range_a: assert property (h2d_valid && ev_q |->
        h2d_data inside {[8'h04:8'h54]})
        else $error("count byte out of range");
    rsp_count_a: assert property ($rose(d2h_valid) |-> d2h_data == 8'h04)
        else $error("response does not open with count four");
    rsp_hold_a: assert property (d2h_valid && !d2h_ready && !h2d_valid
        |=> d2h_valid && $stable(d2h_data))
        else $error("response byte changed before it was taken");
    rsp_status_a: assert property (take && take_n_q == 2'h1 |->
        d2h_data inside {8'h00, 8'h03, 8'h0f, 8'h11, 8'hff})
        else $error("unknown status code");
    crc_low_a: assert property (take && take_n_q == 2'h2 |->
        d2h_data == crc_q[7:0])
        else $error("checksum low byte wrong");
    crc_high_a: assert property (take && take_n_q == 2'h3 |->
        d2h_data == crc_q[15:8])
        else $error("checksum high byte wrong");
    rsp_end_a: assert property (take && take_n_q == 2'h3 |=> !d2h_valid)
        else $error("response runs past four bytes");
    cover property ($rose(d2h_valid));
    cover property (take && take_n_q == 2'h3);
    cover property (h2d_event ##[1:4] h2d_valid);
endmodule : cbf_link_sva

//--- verif/command_block_framer_bench.sv
// Self-checking bench joining the host and device ends of the framer.
`timescale 1ns/1ps
`include "cbf_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end end
module command_block_framer_bench;
    import cbf_pkg::*;
    localparam int unsigned IDLE_N = 50; // Short idle timeout.
    logic        clk = 1'b0;
    logic        rst_h, rst_d, mode_i2c, wdog, exec_done, exec_reject;
    logic        cmd_start, tx_next_q, cmd_refused_q, rsp_valid_q;
    logic        rsp_done_q, rsp_crc_ok_q, cmd_valid_q, busy_q, asleep_q;
    logic [6:0]  cmd_len, data_idx, pkt_len_q;
    cbf_byte_t   tx_byte, rsp_byte_q, exec_status, opcode_q, fp_q, db_q;
    logic [15:0] sp_q;
    int          n_tests = 0, n_mismatch = 0, cycles = 0, tx_idx = 0;
    int          seed = 50509;
    cbf_byte_t   pkt[0:83];
    logic [38:0] exp_cmd[$], ec;
    cbf_byte_t   exp_rsp[$], er;
    cbf_byte_t   codes[4] = '{8'h00, 8'h0f, 8'h11, 8'hff};

    always #2.5 clk = ~clk;
    // ======================================================================
    // Both ends face each other; host reset is separate to recover it.
    cbf_if lnk ();
    cbf_host i_cbf_host (.clk(clk), .rst(rst_h), .lnk(lnk),
        .cmd_start(cmd_start), .cmd_len(cmd_len), .tx_byte(tx_byte),
        .tx_next_q(tx_next_q), .cmd_refused_q(cmd_refused_q),
        .rsp_valid_q(rsp_valid_q), .rsp_byte_q(rsp_byte_q),
        .rsp_done_q(rsp_done_q), .rsp_crc_ok_q(rsp_crc_ok_q));
    cbf_dev #(.IDLE_CYCLES(IDLE_N)) i_cbf_dev (.clk(clk), .rst(rst_d),
        .lnk(lnk), .mode_i2c(mode_i2c), .watchdog_expire(wdog),
        .exec_done(exec_done), .exec_reject(exec_reject),
        .exec_status(exec_status), .data_idx(data_idx),
        .cmd_valid_q(cmd_valid_q), .opcode_q(opcode_q),
        .first_parameter_q(fp_q), .second_parameter_q(sp_q),
        .pkt_len_q(pkt_len_q), .data_byte_q(db_q), .busy_q(busy_q),
        .asleep_q(asleep_q));
    cbf_link_sva i_cbf_link_sva (.clk(clk), .rst(rst_d),
        .h2d_valid(lnk.h2d_valid), .h2d_data(lnk.h2d_data),
        .h2d_event(lnk.h2d_event), .d2h_valid(lnk.d2h_valid),
        .d2h_data(lnk.d2h_data), .d2h_ready(lnk.d2h_ready));

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // Present the next packet byte once the host reports the last taken.
    always @(posedge clk) begin
        if (tx_next_q) begin
            tx_idx  <= tx_idx + 1;
            tx_byte <= pkt[(tx_idx + 1) % 84];
        end
    end

    // Watch the outputs and retire the oldest note of each kind.
    always @(posedge clk) begin
        cycles++;
        if (cmd_valid_q) begin
            ec = exp_cmd.pop_front();
            `CHK("command", ec, {opcode_q, fp_q, sp_q, pkt_len_q})
            `CHK("busy", 1'b1, busy_q)
        end
        if (busy_q) `CHK("quiet", 1'b0, lnk.d2h_valid)
        if (rsp_valid_q) begin
            er = exp_rsp.pop_front();
            `CHK("status", er, rsp_byte_q)
        end
        if (rsp_done_q) `CHK("crc_ok", 1'b1, rsp_crc_ok_q)
        if (cycles > 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic start_cmd(input int len);
        cmd_len   <= 7'(len);
        tx_byte   <= pkt[0];
        tx_idx    <= 0;
        cmd_start <= 1'b1;
        @(posedge clk) cmd_start <= 1'b0;
    endtask : start_cmd

    // A one-byte command: its count wakes the device, the rest is a
    // short block; the stuck host is then reset on its own.
    task automatic wake_junk();
        pkt[0] = 8'h04;
        start_cmd(1);
        repeat (20) @(posedge clk);
        rst_h <= 1'b1;
        @(posedge clk) rst_h <= 1'b0;
        @(posedge clk);
    endtask : wake_junk

    task automatic run_cmd(input int len, input cbf_byte_t st,
                           input logic rej);
        int k;
        for (k = 0; k < len; k++) pkt[k] = 8'($random(seed));
        exp_cmd.push_back({pkt[0], pkt[1], pkt[3], pkt[2], 7'(len)});
        exp_rsp.push_back(rej ? `CBF_ST_PARSE : st);
        start_cmd(len);
        for (k = 0; k < 400 && !cmd_valid_q; k++) @(posedge clk);
        // A packet of four has no data, so look past the store for zero.
        data_idx <= (len > 4) ? 7'(len - 5) : 7'h50;
        repeat (3) @(posedge clk);
        `CHK("data", (len > 4) ? pkt[len - 1] : 8'h00, db_q)
        repeat (1 + {$random(seed)} % 8) @(posedge clk);
        exec_status <= st;
        exec_reject <= rej;
        exec_done   <= 1'b1;
        @(posedge clk) exec_done <= 1'b0;
        for (k = 0; k < 400 && !rsp_done_q; k++) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : run_cmd

    task automatic refuse(input int len);
        int k;
        start_cmd(len);
        for (k = 0; k < 10 && !cmd_refused_q; k++) @(posedge clk);
        `CHK("refused", 1'b1, cmd_refused_q)
    endtask : refuse

    // Main sequence.
    initial begin
        {rst_h, rst_d} = 2'h3;
        {mode_i2c, wdog, exec_done, exec_reject, cmd_start} = 5'h00;
        {exec_status, tx_byte} = 16'h0000;
        {cmd_len, data_idx} = 14'h0000;
        repeat (5) @(posedge clk);
        {rst_h, rst_d} <= 2'h0;
        @(posedge clk);
        wake_junk();
        `CHK("awake", 1'b0, asleep_q)
        repeat (IDLE_N + 10) @(posedge clk);
        `CHK("idle_sleep", 1'b1, asleep_q)
        $display("test single_wire_timeout done");
        mode_i2c <= 1'b1;
        wake_junk();
        repeat (IDLE_N + 10) @(posedge clk);
        `CHK("i2c_wait", 1'b0, asleep_q)
        wdog <= 1'b1;
        @(posedge clk) wdog <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("wdog_sleep", 1'b1, asleep_q)
        $display("test i2c_watchdog done");
        wake_junk();
        foreach (codes[i]) run_cmd(4 + {$random(seed)} % 17, codes[i], 1'b0);
        run_cmd(4, `CBF_ST_OK, 1'b1);
        run_cmd(81, `CBF_ST_OK, 1'b0);
        $display("test commands done");
        refuse(0);
        refuse(82);
        $display("test refusals done");
        // A mid-run device reset leaves it asleep, so the next count is a
        // wake token and the block lands one byte late: checksum fails.
        rst_d <= 1'b1;
        @(posedge clk) rst_d <= 1'b0;
        @(posedge clk);
        pkt[0] = 8'h04;
        pkt[1] = 8'($random(seed));
        exp_rsp.push_back(`CBF_ST_CRC);
        start_cmd(2);
        repeat (30) @(posedge clk);
        `CHK("crc_rsp", 0, exp_rsp.size())
        `CHK("crc_no_run", 1'b0, busy_q)
        $display("test crc_error done");
        give_verdict();
    end
endmodule : command_block_framer_bench
